// file: oad_cfg.svh
// constants for the operand address decoder
`ifndef OAD_CFG_SVH
`define OAD_CFG_SVH
`define OAD_FORM_NODISP   2'b00
`define OAD_FORM_DISP8    2'b01
`define OAD_FORM_DISP16   2'b10
`define OAD_FORM_REG      2'b11
`define OAD_RM_DIRECT     3'b110
`define OAD_FORM_MSB      7
`define OAD_FORM_LSB      6
`define OAD_REG_MSB       5
`define OAD_REG_LSB       3
`define OAD_RM_MSB        2
`define OAD_RM_LSB        0
`define OAD_CALC_NS       160
`define OAD_CLK_NS        40
`define OAD_CALC_CYCLES   (`OAD_CALC_NS / `OAD_CLK_NS)
`endif

// file: oad_pkg.sv
// types for the operand address decoder
package oad_pkg;
  typedef enum logic [1:0] {
    OAD_SEG_EXTRA = 2'b00,
    OAD_SEG_CODE  = 2'b01,
    OAD_SEG_STACK = 2'b10,
    OAD_SEG_DATA  = 2'b11
  } oad_seg_t;
  typedef enum logic [4:0] {
    OAD_IDLE  = 5'b0_0001,
    OAD_DLOW  = 5'b0_0010,
    OAD_DHIGH = 5'b0_0100,
    OAD_CALC  = 5'b0_1000,
    OAD_DONE  = 5'b1_0000
  } oad_state_t;
endpackage

// file: oad_reg_sel.sv
// register-file read selector for word and byte operands
`timescale 1ns/1ps
`include "oad_cfg.svh"
module oad_reg_sel (
  // selection
  input  wire logic [2:0]  sel,
  input  wire logic        word_sel,
  // register file contents
  input  wire logic [15:0] accum_word,
  input  wire logic [15:0] count_word,
  input  wire logic [15:0] data_word,
  input  wire logic [15:0] base_word,
  input  wire logic [15:0] stack_pointer_word,
  input  wire logic [15:0] frame_base_word,
  input  wire logic [15:0] src_index_word,
  input  wire logic [15:0] dest_index_word,
  // selected value, byte operands zero extended
  output logic      [15:0] value
);
  logic [15:0] word_v; // word pick
  logic [15:0] gp_v;   // general register of the same low code
  // word or byte pick by size bit
  always_comb begin
    unique case (sel)
      3'd0: word_v = accum_word;
      3'd1: word_v = count_word;
      3'd2: word_v = data_word;
      3'd3: word_v = base_word;
      3'd4: word_v = stack_pointer_word;
      3'd5: word_v = frame_base_word;
      3'd6: word_v = src_index_word;
      3'd7: word_v = dest_index_word;
    endcase
    unique case (sel[1:0])
      2'd0: gp_v = accum_word;
      2'd1: gp_v = count_word;
      2'd2: gp_v = data_word;
      2'd3: gp_v = base_word;
    endcase
    // bytes: low halves then high halves
    if (word_sel) begin
      value = word_v;
    end else if (sel[2]) begin
      value = {8'h00, gp_v[15:8]};
    end else begin
      value = {8'h00, gp_v[7:0]};
    end
  end
endmodule

// file: oad_decoder.sv
// operand addressing byte decoder and effective offset unit
`timescale 1ns/1ps
`include "oad_cfg.svh"
// Overview of operation
// - form 11: register operand, no offset
// - form 00: zero displacement, no bytes
// - form 01: one byte, sign extended
// - form 10: two bytes, low first
// - codes 000-011: base plus index plus displacement
// - codes 100-111: single register plus displacement
// - form 00 code 110: direct address
// - displacement follows second byte, before immediates
// - offset calculation takes four clocks
// - segment code maps extra, code, stack, data
// - register field by size bit
// - frame base operands use stack segment
// - string destination always extra segment
module oad_decoder #(
  parameter int CALC_CYCLES = `OAD_CALC_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  // addressing byte from the fetch queue
  input  wire logic        modrm_valid,
  input  wire logic [7:0]  modrm_byte,
  input  wire logic        word_sel,
  input  wire logic        string_dest,
  input  wire logic        seg_override,
  input  wire logic [1:0]  seg_override_code,
  // following instruction stream bytes
  input  wire logic        byte_valid,
  input  wire logic [7:0]  stream_byte,
  // segment code field to decode
  input  wire logic [1:0]  seg_code,
  // register file contents
  input  wire logic [15:0] accum_word,
  input  wire logic [15:0] count_word,
  input  wire logic [15:0] data_word,
  input  wire logic [15:0] base_word,
  input  wire logic [15:0] stack_pointer_word,
  input  wire logic [15:0] frame_base_word,
  input  wire logic [15:0] src_index_word,
  input  wire logic [15:0] dest_index_word,
  // handshakes
  output logic             busy,
  output logic             byte_take,
  output logic             imm_ready,
  // results
  output logic             done_ff,
  output logic             reg_operand_ff,
  output logic [2:0]       reg_field_ff,
  output logic [2:0]       rm_reg_ff,
  output logic [15:0]      reg_value_ff,
  output logic [15:0]      rm_value_ff,
  output logic [15:0]      effective_offset_ff,
  output logic [1:0]       operand_seg_ff,
  output logic [1:0]       decoded_seg_ff
);
  logic              rst_s1_ff;  // reset synchroniser stage one
  logic              rst_n_ff;   // synchronised reset
  oad_pkg::oad_state_t state_ff; // sequencer state
  oad_pkg::oad_state_t nxt_state;
  logic [1:0]        form_ff;    // addressing form latched
  logic [2:0]        rm_ff;      // memory-or-register code
  logic              word_ff;    // size bit latched
  logic              strd_ff;    // string destination latched
  logic              ovr_ff;     // override present
  logic [1:0]        ovr_code_ff;
  logic [15:0]       disp_ff;    // assembled displacement
  logic [2:0]        cnt_ff;     // calc cycle counter
  logic [15:0]       base_v;     // first addend
  logic [15:0]       index_v;    // second addend
  logic [15:0]       reg_sel_v;  // reg field value
  logic [15:0]       rm_sel_v;   // r/m as register value
  logic              direct_v;   // direct address case
  logic [1:0]        mod_in;
  logic [2:0]        rm_in;

  assign mod_in = modrm_byte[`OAD_FORM_MSB:`OAD_FORM_LSB];
  assign rm_in  = modrm_byte[`OAD_RM_MSB:`OAD_RM_LSB];
  assign direct_v = (form_ff == `OAD_FORM_NODISP) && (rm_ff == `OAD_RM_DIRECT);

  // reset released through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff  <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff  <= rst_s1_ff;
    end
  end

  // reg field and register-form operand readers share one selector type
  oad_reg_sel u_sel_reg (
    .sel                (modrm_byte[`OAD_REG_MSB:`OAD_REG_LSB]),
    .word_sel           (word_sel),
    .accum_word         (accum_word),
    .count_word         (count_word),
    .data_word          (data_word),
    .base_word          (base_word),
    .stack_pointer_word (stack_pointer_word),
    .frame_base_word    (frame_base_word),
    .src_index_word     (src_index_word),
    .dest_index_word    (dest_index_word),
    .value              (reg_sel_v)
  );
  oad_reg_sel u_sel_rm (
    .sel                (rm_in),
    .word_sel           (word_sel),
    .accum_word         (accum_word),
    .count_word         (count_word),
    .data_word          (data_word),
    .base_word          (base_word),
    .stack_pointer_word (stack_pointer_word),
    .frame_base_word    (frame_base_word),
    .src_index_word     (src_index_word),
    .dest_index_word    (dest_index_word),
    .value              (rm_sel_v)
  );

  // handshakes: stream bytes only taken in displacement states
  assign busy      = (state_ff != oad_pkg::OAD_IDLE);
  assign byte_take = byte_valid && clk_en &&
                     ((state_ff == oad_pkg::OAD_DLOW) || (state_ff == oad_pkg::OAD_DHIGH));
  // immediates may be fetched only once displacement bytes are consumed
  assign imm_ready = (state_ff == oad_pkg::OAD_CALC) || (state_ff == oad_pkg::OAD_DONE);

  // next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      oad_pkg::OAD_IDLE: begin
        if (modrm_valid) begin
          if (mod_in == `OAD_FORM_REG) begin
            nxt_state = oad_pkg::OAD_DONE;
          end else if (mod_in == `OAD_FORM_NODISP && rm_in != `OAD_RM_DIRECT) begin
            nxt_state = oad_pkg::OAD_CALC;
          end else begin
            nxt_state = oad_pkg::OAD_DLOW;
          end
        end
      end
      oad_pkg::OAD_DLOW: begin
        if (byte_valid) begin
          // form 01 has no high byte
          nxt_state = (form_ff == `OAD_FORM_DISP8) ? oad_pkg::OAD_CALC : oad_pkg::OAD_DHIGH;
        end
      end
      oad_pkg::OAD_DHIGH: begin
        if (byte_valid) begin
          nxt_state = oad_pkg::OAD_CALC;
        end
      end
      oad_pkg::OAD_CALC: begin
        if (cnt_ff == 3'(CALC_CYCLES - 1)) begin
          nxt_state = oad_pkg::OAD_DONE;
        end
      end
      oad_pkg::OAD_DONE: begin
        nxt_state = oad_pkg::OAD_IDLE;
      end
      default: nxt_state = oad_pkg::OAD_IDLE;
    endcase
  end

  // sequencer state
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= oad_pkg::OAD_IDLE;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // calc cycle counter, restarts on every entry
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cnt_ff <= 3'h0;
    end else if (clk_en) begin
      cnt_ff <= (state_ff == oad_pkg::OAD_CALC) ? cnt_ff + 3'h1 : 3'h0;
    end
  end

  // latch addressing byte fields and register-form values
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      form_ff        <= 2'h0;
      rm_ff          <= 3'h0;
      word_ff        <= 1'b0;
      strd_ff        <= 1'b0;
      ovr_ff         <= 1'b0;
      ovr_code_ff    <= 2'h0;
      reg_field_ff   <= 3'h0;
      rm_reg_ff      <= 3'h0;
      reg_value_ff   <= 16'h0000;
      rm_value_ff    <= 16'h0000;
      reg_operand_ff <= 1'b0;
    end else if (clk_en && state_ff == oad_pkg::OAD_IDLE && modrm_valid) begin
      form_ff        <= mod_in;
      rm_ff          <= rm_in;
      word_ff        <= word_sel;
      strd_ff        <= string_dest;
      ovr_ff         <= seg_override;
      ovr_code_ff    <= seg_override_code;
      reg_field_ff   <= modrm_byte[`OAD_REG_MSB:`OAD_REG_LSB];
      rm_reg_ff      <= rm_in;
      reg_value_ff   <= reg_sel_v;
      rm_value_ff    <= rm_sel_v;
      reg_operand_ff <= (mod_in == `OAD_FORM_REG);
    end
  end

  // displacement assembly
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      disp_ff <= 16'h0000;
    end else if (clk_en) begin
      if (state_ff == oad_pkg::OAD_IDLE) begin
        disp_ff <= 16'h0000;
      end else if (state_ff == oad_pkg::OAD_DLOW && byte_valid) begin
        // one byte form sign extends, others keep low byte
        disp_ff <= (form_ff == `OAD_FORM_DISP8) ? {{8{stream_byte[7]}}, stream_byte} : {8'h00, stream_byte};
      end else if (state_ff == oad_pkg::OAD_DHIGH && byte_valid) begin
        disp_ff <= {stream_byte, disp_ff[7:0]};
      end
    end
  end

  // addend selection by r/m code
  always_comb begin
    unique case (rm_ff)
      3'd0: begin base_v = base_word;       index_v = src_index_word;  end
      3'd1: begin base_v = base_word;       index_v = dest_index_word; end
      3'd2: begin base_v = frame_base_word; index_v = src_index_word;  end
      3'd3: begin base_v = frame_base_word; index_v = dest_index_word; end
      3'd4: begin base_v = src_index_word;  index_v = 16'h0000;        end
      3'd5: begin base_v = dest_index_word; index_v = 16'h0000;        end
      3'd6: begin base_v = direct_v ? 16'h0000 : frame_base_word; index_v = 16'h0000; end
      3'd7: begin base_v = base_word;       index_v = 16'h0000;        end
    endcase
  end

  // offset and segment, captured on the last calc cycle
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      effective_offset_ff <= 16'h0000;
      operand_seg_ff      <= 2'h3;
    end else if (clk_en && state_ff == oad_pkg::OAD_CALC && cnt_ff == 3'(CALC_CYCLES - 1)) begin
      // 16-bit target drops the carry
      effective_offset_ff <= 16'(base_v + index_v + disp_ff);
      if (strd_ff) begin
        operand_seg_ff <= oad_pkg::OAD_SEG_EXTRA;
      end else if (ovr_ff) begin
        operand_seg_ff <= ovr_code_ff;
      end else if (!direct_v && (rm_ff == 3'd2 || rm_ff == 3'd3 || rm_ff == 3'd6)) begin
        operand_seg_ff <= oad_pkg::OAD_SEG_STACK;
      end else begin
        operand_seg_ff <= oad_pkg::OAD_SEG_DATA;
      end
    end
  end

  // completion pulse and segment field decode
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      done_ff        <= 1'b0;
      decoded_seg_ff <= 2'h0;
    end else if (clk_en) begin
      done_ff        <= (nxt_state == oad_pkg::OAD_DONE);
      decoded_seg_ff <= oad_pkg::oad_seg_t'(seg_code);
    end
  end

  // checks
  a_reg_no_calc: assert property (@(posedge clk) disable iff (!rst_n_ff)
    (clk_en && state_ff == oad_pkg::OAD_IDLE && modrm_valid && mod_in == `OAD_FORM_REG)
    |=> state_ff == oad_pkg::OAD_DONE) else $error("register form entered calc");
  a_calc_four: assert property (@(posedge clk) disable iff (!rst_n_ff)
    ($rose(state_ff == oad_pkg::OAD_CALC) && clk_en) |-> (state_ff == oad_pkg::OAD_CALC)[*4])
    else $error("calc not four cycles");
  a_disp_sext: assert property (@(posedge clk) disable iff (!rst_n_ff)
    (clk_en && state_ff == oad_pkg::OAD_DLOW && byte_valid && form_ff == `OAD_FORM_DISP8)
    |=> disp_ff == {{8{$past(stream_byte[7])}}, $past(stream_byte)}) else $error("bad sign extension");
  a_disp_high: assert property (@(posedge clk) disable iff (!rst_n_ff)
    (clk_en && state_ff == oad_pkg::OAD_DHIGH && byte_valid) |=> disp_ff[15:8] == $past(stream_byte))
    else $error("high byte misplaced");
  a_nodisp_zero: assert property (@(posedge clk) disable iff (!rst_n_ff)
    (state_ff == oad_pkg::OAD_CALC && form_ff == `OAD_FORM_NODISP && !direct_v) |-> disp_ff == 16'h0000)
    else $error("nonzero displacement");
  a_no_early_imm: assert property (@(posedge clk) disable iff (!rst_n_ff)
    (state_ff == oad_pkg::OAD_DLOW || state_ff == oad_pkg::OAD_DHIGH) |-> !imm_ready)
    else $error("immediate before displacement");
  a_string_es: assert property (@(posedge clk) disable iff (!rst_n_ff)
    (clk_en && state_ff == oad_pkg::OAD_CALC && cnt_ff == 3'd3 && strd_ff) |=> operand_seg_ff == 2'b00)
    else $error("string destination not extra");
  a_frame_ss: assert property (@(posedge clk) disable iff (!rst_n_ff)
    (clk_en && state_ff == oad_pkg::OAD_CALC && cnt_ff == 3'd3 && !strd_ff && !ovr_ff && rm_ff == 3'd2)
    |=> operand_seg_ff == 2'b10) else $error("frame base not stack");
  a_seg_map: assert property (@(posedge clk) disable iff (!rst_n_ff)
    clk_en |=> decoded_seg_ff == $past(seg_code)) else $error("segment decode wrong");
  a_offset_wrap: assert property (@(posedge clk) disable iff (!rst_n_ff)
    (clk_en && state_ff == oad_pkg::OAD_CALC && cnt_ff == 3'd3 && rm_ff == 3'd7)
    |=> effective_offset_ff == 16'($past(base_word) + $past(disp_ff))) else $error("offset wrong");
  c_reg_form: cover property (@(posedge clk) reg_operand_ff && done_ff);
  c_disp16: cover property (@(posedge clk) state_ff == oad_pkg::OAD_DHIGH && byte_valid && !direct_v);
  c_direct: cover property (@(posedge clk) state_ff == oad_pkg::OAD_CALC && direct_v);
  c_string: cover property (@(posedge clk) done_ff && strd_ff);
endmodule

// file: oad_fetch_model.sv
// fetch queue model that hands displacement bytes to the decoder
`timescale 1ns/1ps
module oad_fetch_model (
  // clock and freeze
  input  wire logic       clk,
  input  wire logic       clk_en,
  // byte handshake
  input  wire logic       byte_take,
  output logic            byte_valid,
  output logic [7:0]      stream_byte
);
  logic [7:0] q_data[$];  // queued bytes, oldest first
  int         q_gap[$];   // idle cycles before each byte
  int         takes;      // bytes consumed so far
  bit         took;       // head taken at last rising edge
  bit         drop;       // flush requested by the bench
  // bench side loading
  task automatic push(input logic [7:0] b, input int gap);
    q_data.push_back(b);
    q_gap.push_back(gap);
  endtask
  // queue emptied at once, so bytes pushed on the next edge are kept
  task automatic flush();
    q_data.delete();
    q_gap.delete();
    drop = 1'b1;
  endtask
  initial begin
    byte_valid  = 1'b0;
    stream_byte = 8'h00;
    takes       = 0;
    took        = 1'b0;
    drop        = 1'b0;
  end
  // sample before the decoder's own updates land; a frozen edge takes nothing
  always @(posedge clk) begin
    took = byte_valid && byte_take === 1'b1 && clk_en === 1'b1;
  end
  // bytes change only after the falling edge, one assignment each
  always @(negedge clk) begin
    logic       v;
    logic [7:0] b;
    v = byte_valid;
    b = stream_byte;
    if (took) begin
      void'(q_data.pop_front());
      void'(q_gap.pop_front());
      takes++;
      v = 1'b0;
      b = ~b;  // released line shows no stale byte
    end
    if (drop) begin
      v = 1'b0;  // stale trap byte withdrawn
      drop = 1'b0;
    end
    if (!v && q_data.size() > 0) begin
      if (q_gap[0] > 0) begin
        q_gap[0]--;
        b = b + 8'h53;  // pattern keeps moving while stalled
      end else begin
        v = 1'b1;  // strictly in stream order
        b = q_data[0];
      end
    end
    took        = 1'b0;
    byte_valid  = v;
    stream_byte = b;
  end
endmodule

// file: tb_top.sv
// self-checking bench for the operand address decoder
`timescale 1ns/1ps
module tb_top;
  localparam int CALC = 4;  // short enough already
  logic        clk, reset_n, clk_en, modrm_valid, word_sel, string_dest, seg_override;
  logic [7:0]  modrm_byte;
  logic [1:0]  seg_override_code, seg_code;
  logic [15:0] r[8];  // accum count data base sp frame src dest
  logic        byte_valid, busy, byte_take, imm_ready, done_ff, reg_operand_ff;
  logic [7:0]  stream_byte;
  logic [2:0]  reg_field_ff, rm_reg_ff;
  logic [15:0] reg_value_ff, rm_value_ff, effective_offset_ff;
  logic [1:0]  operand_seg_ff, decoded_seg_ff;
  int          fail_count, checks_done;
  bit          stall_en;
  oad_decoder #(.CALC_CYCLES(CALC)) dut (
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .modrm_valid(modrm_valid), .modrm_byte(modrm_byte),
    .word_sel(word_sel), .string_dest(string_dest), .seg_override(seg_override),
    .seg_override_code(seg_override_code), .byte_valid(byte_valid), .stream_byte(stream_byte),
    .seg_code(seg_code), .accum_word(r[0]), .count_word(r[1]), .data_word(r[2]), .base_word(r[3]),
    .stack_pointer_word(r[4]), .frame_base_word(r[5]), .src_index_word(r[6]), .dest_index_word(r[7]),
    .busy(busy), .byte_take(byte_take), .imm_ready(imm_ready), .done_ff(done_ff),
    .reg_operand_ff(reg_operand_ff), .reg_field_ff(reg_field_ff), .rm_reg_ff(rm_reg_ff),
    .reg_value_ff(reg_value_ff), .rm_value_ff(rm_value_ff), .effective_offset_ff(effective_offset_ff),
    .operand_seg_ff(operand_seg_ff), .decoded_seg_ff(decoded_seg_ff));
  oad_fetch_model fq (
    .clk(clk), .clk_en(clk_en), .byte_take(byte_take), .byte_valid(byte_valid), .stream_byte(stream_byte));
  // free-running core clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // random freeze cycles while stalling is on
  always @(negedge clk) clk_en <= !(stall_en && $urandom_range(3, 0) == 0);
  task automatic chk(input bit ok, input string msg);
    checks_done++;
    if (!ok) begin
      fail_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // offset from registers and displacement, wraps at 16 bits
  function automatic logic [15:0] exp_ea(input logic [7:0] m, input logic [15:0] d);
    case (m[2:0])
      3'd0: return r[3] + r[6] + d;
      3'd1: return r[3] + r[7] + d;
      3'd2: return r[5] + r[6] + d;
      3'd3: return r[5] + r[7] + d;
      3'd4: return r[6] + d;
      3'd5: return r[7] + d;
      3'd6: return (m[7:6] == 2'b00) ? d : r[5] + d;
      default: return r[3] + d;
    endcase
  endfunction
  // word registers, or low bytes then high bytes zero extended
  function automatic logic [15:0] exp_reg(input logic [2:0] s, input logic w);
    if (w) return r[s];
    return s[2] ? {8'h00, r[s[1:0]][15:8]} : {8'h00, r[s[1:0]][7:0]};
  endfunction
  // string destination first, then override, then frame base default
  function automatic logic [1:0] exp_seg(input logic [7:0] m, input logic sd, input logic ov,
                                         input logic [1:0] oc);
    if (sd) return oad_pkg::OAD_SEG_EXTRA;
    if (ov) return oc;
    if (m[2:1] == 2'b01 || (m[2:0] == 3'b110 && m[7:6] != 2'b00)) return oad_pkg::OAD_SEG_STACK;
    return oad_pkg::OAD_SEG_DATA;
  endfunction
  // one decode, entered and left just after a falling edge
  task automatic run_op(input logic [7:0] m, input logic [7:0] b0, input logic [7:0] b1,
                        input int g0, input int g1, input bit timed);
    int          nb, lat, t0;
    logic [15:0] d;
    bit          dir;
    dir = (m[7:6] == 2'b00 && m[2:0] == 3'b110);
    nb  = (m[7:6] == 2'b01) ? 1 : (m[7:6] == 2'b10 || dir) ? 2 : 0;
    d   = (nb == 1) ? {{8{b0[7]}}, b0} : (nb == 2) ? {b1, b0} : 16'h0000;
    for (int i = 0; i < 8; i++) r[i] = 16'($urandom);
    if (nb > 0) fq.push(b0, g0);
    if (nb > 1) fq.push(b1, g1);
    if (nb == 0) fq.push(b0, 0);  // trap byte, must stay untaken
    t0 = fq.takes;
    modrm_byte        = m;
    word_sel          = 1'($urandom);
    string_dest       = 1'($urandom_range(3, 0) == 0);
    seg_override      = 1'($urandom);
    seg_override_code = 2'($urandom);
    seg_code          = 2'($urandom);
    modrm_valid       = 1'b1;
    for (lat = 0; lat <= 50; lat++) begin
      @(posedge clk);
      if (clk_en === 1'b1 && busy === 1'b0) break;
    end
    @(negedge clk);
    modrm_valid = 1'b0;
    for (lat = 1; lat <= 300; lat++) begin
      @(posedge clk);
      if (done_ff === 1'b1) break;
    end
    if (lat > 300) begin
      chk(0, "no completion");
      close_out();
    end
    if (timed) chk(lat == ((m[7:6] == 2'b11) ? 1 : nb + 1 + CALC), "latency");
    chk(reg_operand_ff === (m[7:6] == 2'b11), "register operand flag");
    chk(reg_field_ff === m[5:3] && rm_reg_ff === m[2:0], "fields");
    chk(reg_value_ff === exp_reg(m[5:3], word_sel), "reg value");
    chk(decoded_seg_ff === seg_code, "segment decode");
    if (m[7:6] == 2'b11) begin
      chk(rm_value_ff === exp_reg(m[2:0], word_sel), "rm register value");
    end else begin
      chk(effective_offset_ff === exp_ea(m, d), "offset");
      chk(operand_seg_ff === exp_seg(m, string_dest, seg_override, seg_override_code), "operand seg");
      chk(imm_ready === 1'b1, "immediate ready");
    end
    @(negedge clk);
    chk(fq.takes - t0 == nb, "displacement byte count");
    // freeze cycles may hold the done state for several edges
    for (int w = 0; w < 20 && (busy !== 1'b0 || done_ff !== 1'b0); w++) @(negedge clk);
    chk(busy === 1'b0 && done_ff === 1'b0, "return to idle");
    fq.flush();
    @(negedge clk);
  endtask
  // reset, corner sweep, then random traffic
  initial begin
    void'($urandom(32'h52affe4d));
    reset_n = 1'b0;
    modrm_valid = 1'b0;
    modrm_byte = 8'h00;
    word_sel = 1'b0;
    string_dest = 1'b0;
    seg_override = 1'b0;
    seg_override_code = 2'b00;
    seg_code = 2'b00;
    stall_en = 1'b0;
    fail_count = 0;
    checks_done = 0;
    for (int i = 0; i < 8; i++) r[i] = 16'h0000;
    repeat (5) @(negedge clk);
    chk(operand_seg_ff === 2'b11 && done_ff === 1'b0 && busy === 1'b0, "reset values");
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    // every form with every r/m code, sign boundary bytes, prompt fetch
    for (int f = 0; f < 4; f++) begin
      for (int k = 0; k < 8; k++) begin
        run_op({f[1:0], 3'($urandom), k[2:0]}, k[0] ? 8'h80 : 8'h7f, 8'($urandom), 0, 0, 1);
        run_op({f[1:0], 3'($urandom), k[2:0]}, 8'($urandom), 8'($urandom), 0, 0, 1);
      end
    end
    // random traffic with slow fetch and freeze cycles
    stall_en = 1'b1;
    repeat (150) run_op(8'($urandom), 8'($urandom), 8'($urandom), $urandom_range(3, 0),
                        $urandom_range(3, 0), 0);
    stall_en = 1'b0;
    repeat (2) @(negedge clk);
    close_out();
  end
endmodule
